// [logic/cpib_port.sv]
// Processor interrupt port: masking, preemption, acknowledge, completion, bypass
// Functional notes
// - When enabled, signal top pending interrupt only if it beats mask and running priority.
// - Acknowledge read returns top pending identifier, else the spurious identifier.
// - Acknowledge makes the interrupt active; higher priority ones may then preempt.
// - Request output drops when no pending interrupt has enough priority.
// - End-of-interrupt write drops running priority and deactivates the interrupt.
// - Split-completion bit: end write only drops priority; deactivate write deactivates.
// - First version always drops and deactivates together, no split option.
// - Top pending query is readable any time and reports its priority.
// - With bypass, disabled signalling passes the legacy input to the processor.
// - Normal and fast requests are active-high logic outputs.
// - Group 1 always uses normal request; Group 0 may use fast request.
// - Fast routing off: normal driven if any group enabled, else bypassed.
// - Fast routing on: fast driven by group 0 enable, normal by group 1.
// - Second version adds four legacy-block bits, one per output and group.
// - Normal, no enables: block bit(s) choose deassert over bypass.
// - Normal, only group 0 enabled: routing off drives group 0, drops group 1.
// - Normal with group 1 enabled drives group 1; both enabled, routing off drives all.
// - Fast driven only when group 0 enable and fast routing are both set.
// - Fast not driven: block bits choose deassert, otherwise legacy input.
// - Wakeup outputs stay valid even with signalling and bypass both off.
// - Active-priority store readable and writable, separate secure and non-secure copies.
`timescale 1ns/1ps
module cpib_port
    import cpib_pkg::*;
#(
    parameter bit VERSION2 = 1'b1,
    parameter int ADR_W    = 8
) (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_srst,
    input  wire logic                  i_wb_cyc,
    input  wire logic                  i_wb_stb,
    input  wire logic                  i_wb_we,
    input  wire logic [ADR_W-1:0]      i_wb_adr,
    input  wire logic [31:0]           i_wb_dat,
    input  wire logic [3:0]            i_wb_sel,
    input  wire logic                  i_secure_access,
    output logic      [31:0]           o_wb_dat,
    output logic                       o_wb_ack,
    input  wire logic                  i_dist_valid,
    input  wire logic [CPIB_ID_W-1:0]  i_dist_id,
    input  wire logic [CPIB_PRI_W-1:0] i_dist_pri,
    input  wire logic                  i_dist_group1,
    output logic                       o_ack_valid,
    output logic      [CPIB_ID_W-1:0]  o_ack_id,
    output logic                       o_deact_valid,
    output logic      [CPIB_ID_W-1:0]  o_deact_id,
    input  wire logic                  i_legacy_normal,
    input  wire logic                  i_legacy_fast,
    output logic                       o_normal_request,
    output logic                       o_fast_request,
    output logic                       o_wake_normal,
    output logic                       o_wake_fast
);
    // ==========================================================
    // Helpers
    function automatic logic [CPIB_LVL_W:0] lowest_level(input logic [CPIB_LVLS-1:0] v);
        lowest_level = {1'b1, {CPIB_LVL_W{1'b0}}};
        for (int k = CPIB_LVLS - 1; k >= 0; k--) begin
            if (v[k]) begin
                lowest_level = {1'b0, k[CPIB_LVL_W-1:0]};
            end
        end
    endfunction : lowest_level

    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] sel);
        for (int b = 0; b < 4; b++) begin
            lane_merge[b*8 +: 8] = sel[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction : lane_merge

    // ==========================================================
    // State
    logic [CPIB_CTRL_W-1:0] ctrl;
    logic [CPIB_PRI_W-1:0]  pmask;
    logic [CPIB_LVLS-1:0]   apr_s;
    logic [CPIB_LVLS-1:0]   apr_ns;
    logic [1:0]             leg_n_sync;
    logic [1:0]             leg_f_sync;

    // ==========================================================
    // Bus decode
    wire            take      = i_wb_cyc && i_wb_stb && !o_wb_ack;
    wire [7:0]      adr       = i_wb_adr[7:0];
    wire            wr        = take && i_wb_we;
    wire            rd        = take && !i_wb_we;
    wire            rd_ack    = rd && adr == CPIB_OFF_ACK;
    wire            wr_eoi    = wr && adr == CPIB_OFF_EOI;
    wire            wr_deact  = wr && adr == CPIB_OFF_DEACT;
    wire            wr_ctrl   = wr && adr == CPIB_OFF_CTRL;
    wire            wr_mask   = wr && adr == CPIB_OFF_MASK;
    // Non-secure save/restore writes never reach the secure copy; acknowledge and drop still update it
    wire            wr_apr_s  = wr && adr == CPIB_OFF_APR_S && i_secure_access;
    wire            wr_apr_ns = wr && adr == CPIB_OFF_APR_NS;

    // ==========================================================
    // Control fields; first version has no split or block bits
    wire g0_en    = ctrl[CPIB_B_G0_EN];
    wire g1_en    = ctrl[CPIB_B_G1_EN];
    wire froute   = ctrl[CPIB_B_FROUTE];
    wire split    = VERSION2 && ctrl[CPIB_B_SPLIT];
    wire fblk0    = VERSION2 && ctrl[CPIB_B_FBLK_G0];
    wire fblk1    = VERSION2 && ctrl[CPIB_B_FBLK_G1];
    wire nblk0    = VERSION2 && ctrl[CPIB_B_NBLK_G0];
    wire nblk1    = VERSION2 && ctrl[CPIB_B_NBLK_G1];
    wire leg_n    = leg_n_sync[1];
    wire leg_f    = leg_f_sync[1];

    // ==========================================================
    // Priority: running priority is the best level held in either copy
    wire [CPIB_LVLS-1:0]  apr_all  = apr_s | apr_ns;
    wire [CPIB_LVL_W:0]   run_lvl  = lowest_level(apr_all);
    wire [CPIB_PRI_W-1:0] run_pri  = run_lvl[CPIB_LVL_W] ? CPIB_IDLE_PRI
                                     : {run_lvl[CPIB_LVL_W-1:0], {CPIB_SUB_W{1'b0}}};
    wire [CPIB_LVL_W-1:0] pend_lvl = i_dist_pri[CPIB_PRI_W-1 -: CPIB_LVL_W];
    // Preemption compares group levels only, sub-priority never preempts
    wire pend_ok  = i_dist_valid && i_dist_pri < pmask
                    && (run_lvl[CPIB_LVL_W] || pend_lvl < run_lvl[CPIB_LVL_W-1:0]);
    wire grp_en   = i_dist_group1 ? g1_en : g0_en;
    wire elig     = pend_ok && grp_en;
    wire fast_grp = !i_dist_group1 && froute;

    // ==========================================================
    // Output source selection, purely from control bits and pending group
    wire n_owner  = g1_en || (g0_en && !froute);
    wire n_val    = pend_ok && (i_dist_group1 ? g1_en : (g0_en && !froute));
    wire n_block  = froute ? (nblk0 && nblk1) : nblk1;
    wire f_owner  = g0_en && froute;
    wire f_val    = pend_ok && fast_grp && g0_en;
    wire f_block  = froute ? fblk0 : (fblk0 && fblk1);
    cpib_src_e n_src;
    cpib_src_e f_src;
    assign n_src  = n_owner ? CPIB_SRC_CTRL : (n_block ? CPIB_SRC_OFF : CPIB_SRC_BYPASS);
    assign f_src  = f_owner ? CPIB_SRC_CTRL : (f_block ? CPIB_SRC_OFF : CPIB_SRC_BYPASS);

    logic next_normal;
    logic next_fast;
    always_comb begin
        case (n_src)
            CPIB_SRC_CTRL:   next_normal = n_val;
            CPIB_SRC_BYPASS: next_normal = leg_n;
            CPIB_SRC_OFF:    next_normal = 1'b0;
            default:         next_normal = 1'b0;
        endcase
        case (f_src)
            CPIB_SRC_CTRL:   next_fast = f_val;
            CPIB_SRC_BYPASS: next_fast = leg_f;
            CPIB_SRC_OFF:    next_fast = 1'b0;
            default:         next_fast = 1'b0;
        endcase
    end

    // Wakeups ignore enables and block bits so they survive a full shutdown
    wire next_wake_n = leg_n || (pend_ok && !fast_grp);
    wire next_wake_f = leg_f || (pend_ok && fast_grp);

    // ==========================================================
    // Completion: drop clears the best active level wherever it is held
    wire                 do_drop  = wr_eoi && !run_lvl[CPIB_LVL_W];
    wire [CPIB_LVLS-1:0] drop_bit = do_drop ? (apr_all & ~(apr_all - 32'd1))
                                            : {CPIB_LVLS{1'b0}};
    wire                 ack_take = rd_ack && elig;
    wire [CPIB_LVLS-1:0] ack_bit  = ack_take ? (32'd1 << pend_lvl) : {CPIB_LVLS{1'b0}};
    wire [31:0]          wd_s     = lane_merge(apr_s, i_wb_dat, i_wb_sel);
    wire [31:0]          wd_ns    = lane_merge(apr_ns, i_wb_dat, i_wb_sel);
    wire [31:0]          wd_ctrl  = lane_merge({{(32-CPIB_CTRL_W){1'b0}}, ctrl}, i_wb_dat, i_wb_sel);
    wire [31:0]          wd_mask  = lane_merge({24'h0, pmask}, i_wb_dat, i_wb_sel);
    wire                 deact_go = (wr_eoi && !split) || (wr_deact && split);

    // ==========================================================
    // Read mux
    logic [31:0] next_rdat;
    always_comb begin
        case (adr)
            CPIB_OFF_CTRL:   next_rdat = {{(32-CPIB_CTRL_W){1'b0}}, ctrl};
            CPIB_OFF_MASK:   next_rdat = {24'h0, pmask};
            CPIB_OFF_ACK:    next_rdat = {22'h0, elig ? i_dist_id : CPIB_SPURIOUS};
            CPIB_OFF_RUN:    next_rdat = {24'h0, run_pri};
            CPIB_OFF_TOP:    next_rdat = i_dist_valid ? {8'h0, i_dist_pri, 6'h0, i_dist_id}
                                                      : {24'h0, 8'h0} | {22'h0, CPIB_SPURIOUS};
            CPIB_OFF_APR_S:  next_rdat = i_secure_access ? apr_s : 32'h0;
            CPIB_OFF_APR_NS: next_rdat = apr_ns;
            CPIB_OFF_STAT:   next_rdat = {24'h0, o_wake_fast, o_wake_normal, leg_f, leg_n,
                                          o_fast_request, o_normal_request, elig, pend_ok};
            default:         next_rdat = 32'h0;
        endcase
    end

    // ==========================================================
    // Registers
    always_ff @(posedge i_core_clk) begin
        leg_n_sync <= {leg_n_sync[0], i_legacy_normal};
        leg_f_sync <= {leg_f_sync[0], i_legacy_fast};
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            ctrl  <= CPIB_CTRL_RST;
            pmask <= CPIB_MASK_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl <= wd_ctrl[CPIB_CTRL_W-1:0];
            end
            if (wr_mask) begin
                pmask <= wd_mask[CPIB_PRI_W-1:0];
            end
        end
    end

    // Acknowledge sets wins over a same-cycle save/restore write
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            apr_s  <= CPIB_APR_RST;
            apr_ns <= CPIB_APR_RST;
        end else begin
            apr_s  <= ((wr_apr_s ? wd_s : apr_s) & ~drop_bit)
                      | (i_dist_group1 ? '0 : ack_bit);
            apr_ns <= ((wr_apr_ns ? wd_ns : apr_ns) & ~drop_bit)
                      | (i_dist_group1 ? ack_bit : '0);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_wb_ack         <= 1'b0;
            o_wb_dat         <= 32'h0;
            o_ack_valid      <= 1'b0;
            o_ack_id         <= '0;
            o_deact_valid    <= 1'b0;
            o_deact_id       <= '0;
            o_normal_request <= 1'b0;
            o_fast_request   <= 1'b0;
            o_wake_normal    <= 1'b0;
            o_wake_fast      <= 1'b0;
        end else begin
            o_wb_ack         <= take;
            o_wb_dat         <= rd ? next_rdat : 32'h0;
            o_ack_valid      <= ack_take;
            o_ack_id         <= ack_take ? i_dist_id : o_ack_id;
            o_deact_valid    <= deact_go;
            o_deact_id       <= deact_go ? i_wb_dat[CPIB_ID_W-1:0] : o_deact_id;
            o_normal_request <= next_normal;
            o_fast_request   <= next_fast;
            o_wake_normal    <= next_wake_n;
            o_wake_fast      <= next_wake_f;
        end
    end

    // ==========================================================
    // Checks
    sequence s_ack_read;
        rd_ack;
    endsequence
    sequence s_eoi_write;
        wr_eoi;
    endsequence
    sequence s_deact_write;
        wr_deact;
    endsequence
    sequence s_top_read;
        rd && adr == CPIB_OFF_TOP;
    endsequence

    a_bus_ack_pulse: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        take |=> o_wb_ack ##1 !o_wb_ack
    ) else $error("bus ack not single cycle");

    a_spurious_read: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        s_ack_read and !elig |=> o_wb_dat == 32'h0000_03ff && !o_ack_valid
    ) else $error("spurious id wrong");

    a_ack_activates: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        s_ack_read and elig |=> o_ack_valid && o_ack_id == $past(i_dist_id)
        && apr_all[$past(pend_lvl)]
    ) else $error("acknowledge did not activate");

    a_top_query: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        s_top_read and i_dist_valid |=> o_wb_dat[CPIB_ID_W-1:0] == $past(i_dist_id)
        && o_wb_dat[23:16] == $past(i_dist_pri)
    ) else $error("top pending query wrong");

    a_drop_on_eoi: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        s_eoi_write and !run_lvl[CPIB_LVL_W] and !ack_take and !wr_apr_s and !wr_apr_ns
        |=> apr_all == ($past(apr_all) & ($past(apr_all) - 32'd1))
    ) else $error("priority drop missing");

    a_split_hold: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        s_eoi_write and split |=> !o_deact_valid
    ) else $error("split end deactivated");

    a_split_deact: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        s_deact_write and split |=> o_deact_valid
        && o_deact_id == $past(i_wb_dat[CPIB_ID_W-1:0])
    ) else $error("deactivate write lost");

    a_joint_deact: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        s_eoi_write and !split |=> o_deact_valid && o_deact_id == $past(i_wb_dat[9:0])
    ) else $error("joint completion missing");

    a_secure_guard: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        wr && adr == CPIB_OFF_APR_S && !i_secure_access |=> apr_s == $past(apr_s)
    ) else $error("secure store disturbed");

    a_request_drop: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        n_owner && !pend_ok |=> !o_normal_request
    ) else $error("normal request not dropped");

    a_fast_mask: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        g0_en && froute && !pend_ok |=> !o_fast_request
    ) else $error("fast request not dropped");

    a_bypass_normal: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        !n_owner && !n_block |=> o_normal_request == $past(leg_n)
    ) else $error("normal bypass broken");

    a_normal_block: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        !g1_en && (froute ? (nblk0 && nblk1) : (!g0_en && nblk1)) |=> !o_normal_request
    ) else $error("blocked normal output active");

    a_normal_group1: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        g1_en && i_dist_group1 && pend_ok |=> o_normal_request
    ) else $error("group 1 request missing");

    a_group0_only: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        g0_en && !g1_en && !froute |=> o_normal_request == $past(pend_ok && !i_dist_group1)
    ) else $error("group 0 only drive wrong");

    a_routed_group0: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        g1_en && froute && !i_dist_group1 |=> !o_normal_request
    ) else $error("routed group 0 on normal output");

    a_fast_group: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        f_owner |=> o_fast_request == $past(pend_ok && !i_dist_group1)
    ) else $error("fast output carries wrong group");

    a_fast_block: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        !f_owner && f_block |=> !o_fast_request
    ) else $error("blocked fast output active");

    a_fast_bypass: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        !(g0_en && froute) && !fblk0 |=> o_fast_request == $past(leg_f)
    ) else $error("fast bypass broken");

    a_wake_alive: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        pend_ok && i_dist_group1 |=> o_wake_normal
    ) else $error("wakeup lost");

    a_wake_fast: assert property (
        @(posedge i_core_clk) disable iff (i_srst)
        pend_ok && froute && !i_dist_group1 |=> o_wake_fast
    ) else $error("fast wakeup lost");

endmodule : cpib_port

// [logic/cpib_pkg.sv]
// Package: register map, control fields and constants of the processor interrupt port
package cpib_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] CPIB_OFF_CTRL   = 8'h00;
    localparam logic [7:0] CPIB_OFF_MASK   = 8'h04;
    localparam logic [7:0] CPIB_OFF_ACK    = 8'h0c;
    localparam logic [7:0] CPIB_OFF_EOI    = 8'h10;
    localparam logic [7:0] CPIB_OFF_RUN    = 8'h14;
    localparam logic [7:0] CPIB_OFF_TOP    = 8'h18;
    localparam logic [7:0] CPIB_OFF_DEACT  = 8'h20;
    localparam logic [7:0] CPIB_OFF_APR_S  = 8'h30;
    localparam logic [7:0] CPIB_OFF_APR_NS = 8'h34;
    localparam logic [7:0] CPIB_OFF_STAT   = 8'h38;

    // ==========================================================
    // Control register field positions
    localparam int CPIB_B_G0_EN   = 0;
    localparam int CPIB_B_G1_EN   = 1;
    localparam int CPIB_B_FROUTE  = 3;
    localparam int CPIB_B_FBLK_G0 = 5;
    localparam int CPIB_B_FBLK_G1 = 6;
    localparam int CPIB_B_NBLK_G0 = 7;
    localparam int CPIB_B_NBLK_G1 = 8;
    localparam int CPIB_B_SPLIT   = 9;
    localparam int CPIB_CTRL_W    = 10;

    // ==========================================================
    // Reset values and fixed codes
    localparam logic [CPIB_CTRL_W-1:0] CPIB_CTRL_RST = 10'h000;
    localparam logic [7:0]  CPIB_MASK_RST = 8'h00;
    localparam logic [31:0] CPIB_APR_RST  = 32'h0000_0000;
    localparam logic [9:0]  CPIB_SPURIOUS = 10'h3ff;
    localparam logic [7:0]  CPIB_IDLE_PRI = 8'hff;
    localparam int          CPIB_ID_W     = 10;
    localparam int          CPIB_PRI_W    = 8;
    localparam int          CPIB_LVL_W    = 5;
    localparam int          CPIB_LVLS     = 32;
    localparam int          CPIB_SUB_W    = 3;

    // ==========================================================
    // Drive source of one request output
    typedef enum logic [2:0] {
        CPIB_SRC_CTRL   = 3'b001,
        CPIB_SRC_BYPASS = 3'b010,
        CPIB_SRC_OFF    = 3'b100
    } cpib_src_e;
endpackage : cpib_pkg

// [verification/cpib_dist_model.sv]
// Distributor stand-in: one top pending interrupt, ack and deactivate counters
`timescale 1ns/1ps
module cpib_dist_model
    import cpib_pkg::*;
(
    input  wire logic                  i_core_clk,
    input  wire logic                  i_load,
    input  wire logic [CPIB_ID_W-1:0]  i_ld_id,
    input  wire logic [CPIB_PRI_W-1:0] i_ld_pri,
    input  wire logic                  i_ld_g1,
    input  wire logic                  i_ack_valid,
    input  wire logic                  i_deact_valid,
    output logic                       o_dist_valid,
    output logic      [CPIB_ID_W-1:0]  o_dist_id,
    output logic      [CPIB_PRI_W-1:0] o_dist_pri,
    output logic                       o_dist_group1,
    output logic      [7:0]            o_ack_cnt,
    output logic      [7:0]            o_deact_cnt
);
    // ==========================================
    // Pending state
    logic [CPIB_ID_W-1:0]  id;
    logic [CPIB_PRI_W-1:0] pri;
    initial begin
        o_dist_valid = 1'b0;
        id = 10'h000;
        pri = 8'h00;
        o_dist_group1 = 1'b0;
        o_ack_cnt = 8'h00;
        o_deact_cnt = 8'h00;
    end
    always @(posedge i_core_clk) begin
        if (i_load) begin
            o_dist_valid <= 1'b1;
            id <= i_ld_id;
            pri <= i_ld_pri;
            o_dist_group1 <= i_ld_g1;
        end else if (i_ack_valid) begin
            o_dist_valid <= 1'b0;
        end
        o_ack_cnt <= o_ack_cnt + {7'h00, i_ack_valid};
        o_deact_cnt <= o_deact_cnt + {7'h00, i_deact_valid};
    end
    // Scrambled while idle so a stale id can never pass for a live one
    assign o_dist_id = o_dist_valid ? id : ~id;
    assign o_dist_pri = o_dist_valid ? pri : ~pri;
endmodule : cpib_dist_model

// [verification/cpib_port_tb_top.sv]
// Testbench: bypass table, acknowledge, completion, masking, store access
`timescale 1ns/1ps
module cpib_port_tb_top
    import cpib_pkg::*;
;
    typedef struct packed {
        logic [9:0] ctrl;
        logic       g1;
        logic [1:0] leg;
        logic [1:0] exp;
    } cpib_row_s;
    logic        clk, srst, cyc, stb, we, sec, ld, ld_g1, ln, lf;
    logic        dv, dg1, ackv, deav, nreq, freq, wack, wkn, wkf;
    logic [7:0]  adr, ld_pri, dpri, ack_cnt, deact_cnt;
    logic [9:0]  ld_id, did, aid, deid;
    logic [31:0] wdat, rdat, got;
    int          err_count, checks, cycles;
    cpib_row_s   rows [16];

    cpib_port u_dut (.i_core_clk(clk), .i_srst(srst), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf),
        .i_secure_access(sec), .o_wb_dat(rdat), .o_wb_ack(wack), .i_dist_valid(dv),
        .i_dist_id(did), .i_dist_pri(dpri), .i_dist_group1(dg1), .o_ack_valid(ackv),
        .o_ack_id(aid), .o_deact_valid(deav), .o_deact_id(deid), .i_legacy_normal(ln),
        .i_legacy_fast(lf), .o_normal_request(nreq), .o_fast_request(freq),
        .o_wake_normal(wkn), .o_wake_fast(wkf));
    cpib_dist_model u_dist (.i_core_clk(clk), .i_load(ld), .i_ld_id(ld_id),
        .i_ld_pri(ld_pri), .i_ld_g1(ld_g1), .i_ack_valid(ackv), .i_deact_valid(deav),
        .o_dist_valid(dv), .o_dist_id(did), .o_dist_pri(dpri), .o_dist_group1(dg1),
        .o_ack_cnt(ack_cnt), .o_deact_cnt(deact_cnt));

    // ==========================================
    // Tasks
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // Classic cycle: request held until ack is seen at an edge, then released
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic s, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sec <= s;
        do begin
            @(posedge clk);
            n++;
        end while (wack !== 1'b1 && n < 50);
        if (n >= 50) err_count++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic s);
        bus(1'b1, a, d, s, got);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic s, input logic [31:0] e);
        bus(1'b0, a, 32'h0, s, got);
        chk(got, e);
    endtask : rdchk
    task automatic load(input logic [9:0] i, input logic [7:0] p, input logic g);
        @(posedge clk);
        ld <= 1'b1;
        ld_id <= i;
        ld_pri <= p;
        ld_g1 <= g;
        @(posedge clk);
        ld <= 1'b0;
        tick(4);
    endtask : load
    task automatic stop_test;
        if (err_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    // ==========================================
    // Clock, timeout, sequence
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Whole sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            stop_test();
        end
    end
    initial begin
        {srst, cyc, stb, we, sec, ld, ld_g1, ln, lf} = 9'h101;
        {adr, ld_pri, ld_id, wdat} = 58'h0;
        rows = '{'{10'h000, 1'b0, 2'h3, 2'h3}, '{10'h100, 1'b0, 2'h3, 2'h2},
                 '{10'h060, 1'b0, 2'h3, 2'h1}, '{10'h108, 1'b0, 2'h3, 2'h3},
                 '{10'h188, 1'b0, 2'h3, 2'h2}, '{10'h028, 1'b0, 2'h3, 2'h1},
                 '{10'h001, 1'b0, 2'h0, 2'h1}, '{10'h001, 1'b1, 2'h3, 2'h2},
                 '{10'h009, 1'b1, 2'h3, 2'h1}, '{10'h009, 1'b0, 2'h0, 2'h2},
                 '{10'h002, 1'b0, 2'h3, 2'h2}, '{10'h002, 1'b1, 2'h0, 2'h1},
                 '{10'h003, 1'b0, 2'h0, 2'h1}, '{10'h00b, 1'b0, 2'h0, 2'h2},
                 '{10'h00b, 1'b1, 2'h0, 2'h1}, '{10'h0e1, 1'b0, 2'h3, 2'h1}};
        tick(10);
        srst <= 1'b0;
        wr(CPIB_OFF_MASK, 32'hff, 1'b1);
        foreach (rows[i]) begin
            {lf, ln} <= rows[i].leg;
            load(10'h011, 8'h10, rows[i].g1);
            wr(CPIB_OFF_CTRL, {22'h0, rows[i].ctrl}, 1'b1);
            tick(5);
            chk({30'h0, freq, nreq}, {30'h0, rows[i].exp});
        end
        {lf, ln} <= 2'b00;
        // Signalling and bypass both shut off: only the wakeups may move
        wr(CPIB_OFF_CTRL, 32'h1e8, 1'b1);
        tick(4);
        chk({28'h0, wkf, wkn, freq, nreq}, 32'h8);
        wr(CPIB_OFF_CTRL, 32'h3, 1'b1);
        load(10'h02a, 8'h10, 1'b0);
        rdchk(CPIB_OFF_ACK, 1'b1, 32'h2a);
        tick(2);
        chk({ack_cnt, 14'h0, aid}, 32'h0100_002a);
        rdchk(CPIB_OFF_RUN, 1'b1, 32'h10);
        rdchk(CPIB_OFF_ACK, 1'b1, 32'h3ff);
        tick(3);
        chk({31'h0, nreq}, 32'h0);
        load(10'h033, 8'h18, 1'b0);
        chk({31'h0, nreq}, 32'h0);
        rdchk(CPIB_OFF_TOP, 1'b1, 32'h0018_0033);
        load(10'h005, 8'h08, 1'b0);
        chk({31'h0, nreq}, 32'h1);
        wr(CPIB_OFF_EOI, 32'h2a, 1'b1);
        load(10'h033, 8'h18, 1'b0);
        chk({deact_cnt, 6'h0, deid, 7'h0, nreq}, 32'h0100_2a01);
        wr(CPIB_OFF_CTRL, 32'h203, 1'b1);
        rdchk(CPIB_OFF_ACK, 1'b1, 32'h33);
        tick(2);
        wr(CPIB_OFF_EOI, 32'h33, 1'b1);
        load(10'h040, 8'h20, 1'b0);
        chk({deact_cnt, 23'h0, nreq}, 32'h0100_0001);
        wr(CPIB_OFF_DEACT, 32'h33, 1'b1);
        tick(2);
        chk({deact_cnt, 6'h0, deid, 8'h0}, 32'h0200_3300);
        wr(CPIB_OFF_MASK, 32'h10, 1'b1);
        tick(4);
        chk({31'h0, nreq}, 32'h0);
        rdchk(CPIB_OFF_ACK, 1'b1, 32'h3ff);
        wr(CPIB_OFF_APR_S, 32'h100, 1'b1);
        wr(CPIB_OFF_APR_S, 32'hffff, 1'b0);
        rdchk(CPIB_OFF_APR_S, 1'b1, 32'h100);
        rdchk(CPIB_OFF_APR_S, 1'b0, 32'h0);
        wr(CPIB_OFF_APR_NS, 32'h80, 1'b0);
        rdchk(CPIB_OFF_APR_NS, 1'b0, 32'h80);
        rdchk(8'h3c, 1'b1, 32'h0);
        srst <= 1'b1;
        tick(10);
        chk({28'h0, nreq, freq, ackv, deav}, 32'h0);
        srst <= 1'b0;
        rdchk(CPIB_OFF_CTRL, 1'b1, 32'h0);
        rdchk(CPIB_OFF_APR_S, 1'b1, 32'h0);
        stop_test();
    end
endmodule : cpib_port_tb_top
